/* sbcc_pkg.sv */
// constants, state types and step table for system bus cycle control
// assumes a 100 MHz REF_CLK shared by the controller and both bus masters
// Notes on behaviour
// - dma pulls bus request low for ownership
// - arbiter asserts grant ack when dma owns
// - idle processor holds address strobe high
// - processor grant low: releases after cycle
// - every decoded non-peripheral address gets transfer acknowledge
// - generate line index sets 100 ns steps
// - gated read/write low on write, high read
// - data strobe drives gated low until acknowledge
// - dma keeps gated read/write high
// - count hardware controls copy gated and read
// - read strobe low until address strobe returns high
// - lower byte strobe from owning master
// - upper byte strobe from owning master
// - owning master drives read/write line
// - peripheral address answered by synced valid address
// - board select three decodes top address
package sbcc_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int STEP_NS       = 100;
   localparam int CYC_PER_STEP  = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ADDR_W        = 18;
   localparam int E_DIV         = 10;
   localparam int CNT_W         = 8;
   // step count per address block, block = A18..A16
   localparam logic [7:0][2:0] BLK_STEPS =
      {3'h2, 3'h2, 3'h3, 3'h1, 3'h5, 3'h3, 3'h2, 3'h1};
   localparam logic [7:0] BLK_IO_MASK   = 8'hf0;
   localparam logic [7:0] BLK_MEAS_MASK = 8'h08;
   localparam logic       STROBE_RST    = 1'b1;

   typedef enum logic [1:0] {
      OWN_PROC    = 2'b00,
      OWN_HANDOFF = 2'b01,
      OWN_DMA     = 2'b10
   } sbcc_own_e;

   typedef enum logic [2:0] {
      CYC_IDLE     = 3'b000,
      CYC_COUNT    = 3'b001,
      CYC_ACK      = 3'b010,
      CYC_VMA_WAIT = 3'b011
   } sbcc_cyc_e;

   typedef enum logic [2:0] {
      M_IDLE = 3'b000,
      M_REQ  = 3'b001,
      M_AS   = 3'b010,
      M_DS   = 3'b011,
      M_WAIT = 3'b100,
      M_REL  = 3'b101
   } sbcc_mst_e;
endpackage

/* sbcc_if.sv */
// link between the bus cycle controller and the bus master end
// two-way lines resolve here as wired-and with pull-ups
`timescale 1ns/100ps
`default_nettype none
interface sbcc_if;
   logic                        bus_req_n;
   logic                        grant_out_n;
   logic                        grant_ack_n;
   logic                        addr_strobe_buf_n;
   logic                        data_strobe_n;
   logic [sbcc_pkg::ADDR_W-1:0] addr;
   logic                        dtack_n;
   logic                        valid_periph_addr_n;
   logic                        valid_mem_addr_n;
   logic                        rw_o;
   logic                        rw_oe_n;
   logic                        low_byte_o;
   logic                        low_byte_oe_n;
   logic                        high_byte_o;
   logic                        high_byte_oe_n;
   logic                        dev_grw_o;
   logic                        dev_grw_oe_n;
   logic                        mst_grw_o;
   logic                        mst_grw_oe_n;
   logic                        meas_read_o;
   logic                        meas_read_oe_n;
   wire                         rw_n;
   wire                         low_byte_strobe_n;
   wire                         high_byte_strobe_n;
   wire                         gated_rd_wr_n;
   wire                         meas_read_n;

   assign rw_n               = rw_oe_n ? 1'b1 : rw_o;
   assign low_byte_strobe_n  = low_byte_oe_n ? 1'b1 : low_byte_o;
   assign high_byte_strobe_n = high_byte_oe_n ? 1'b1 : high_byte_o;
   assign gated_rd_wr_n      = (dev_grw_oe_n ? 1'b1 : dev_grw_o)
                             & (mst_grw_oe_n ? 1'b1 : mst_grw_o);
   assign meas_read_n        = meas_read_oe_n ? 1'b1 : meas_read_o;

   modport ctrl (
      input  bus_req_n, grant_out_n, addr_strobe_buf_n, data_strobe_n, addr,
      input  valid_periph_addr_n, rw_n, low_byte_strobe_n, high_byte_strobe_n,
      input  gated_rd_wr_n, meas_read_n,
      output grant_ack_n, dtack_n, valid_mem_addr_n,
      output dev_grw_o, dev_grw_oe_n, meas_read_o, meas_read_oe_n
   );
   modport master (
      input  grant_ack_n, dtack_n, valid_mem_addr_n, gated_rd_wr_n, meas_read_n,
      output bus_req_n, grant_out_n, addr_strobe_buf_n, data_strobe_n, addr,
      output rw_o, rw_oe_n, low_byte_o, low_byte_oe_n, high_byte_o, high_byte_oe_n,
      output mst_grw_o, mst_grw_oe_n
   );
endinterface
`default_nettype wire

/* sbcc_ctrl.sv */
// bus arbitration and bus-cycle control for the shared system bus
// assumes masters hold address, rw and strobes stable while strobe is low
`timescale 1ns/100ps
`default_nettype none
module sbcc_ctrl (
   input  wire logic REF_CLK,
   input  wire logic RST,
   sbcc_if.ctrl      bus,
   output logic      GEN_ACK_1STEP_N,
   output logic      GEN_ACK_2STEP_N,
   output logic      GEN_ACK_3STEP_N,
   output logic      GEN_ACK_5STEP_N,
   output logic      BOARD_SEL0_N,
   output logic      BOARD_SEL1_N,
   output logic      BOARD_SEL2_N,
   output logic      BOARD_SEL3_N,
   output logic      CNT_HW_WRITE_CTL_N,
   output logic      CNT_HW_READ_CTL_N,
   output logic      DMA_OWNS
);
   typedef struct packed {
      sbcc_pkg::sbcc_own_e         own;
      sbcc_pkg::sbcc_cyc_e         cyc;
      logic [sbcc_pkg::CNT_W-1:0]  cnt;
      logic [sbcc_pkg::CNT_W-1:0]  e_cnt;
      logic                        e_en;
      logic                        gack_n;
      logic                        dtack_n;
      logic                        vma_n;
      logic [3:0]                  gen_n;
      logic                        bs3_n;
      logic                        mrd_n;
      logic                        grw_n;
      logic                        grw_oe_n;
      logic                        cnt_hw_write_ctl_n_n;
      logic                        cnt_hw_read_ctl_n_n;
      logic                        dma_owns;
   } sbcc_ctrl_s;

   sbcc_ctrl_s state_reg;
   sbcc_ctrl_s state_next;

   function automatic logic [3:0] gen_line_n(input logic [2:0] steps);
      logic [3:0] v;
      v = 4'hf;
      case (steps)
         3'h1:    v[0] = 1'b0;
         3'h2:    v[1] = 1'b0;
         3'h3:    v[2] = 1'b0;
         3'h5:    v[3] = 1'b0;
         default: v = 4'hf;
      endcase
      return v;
   endfunction

   always_comb begin
      logic [2:0]                 blk;
      logic [2:0]                 steps;
      logic                       in_cyc;
      logic [sbcc_pkg::CNT_W-1:0] len;
      blk    = bus.addr[sbcc_pkg::ADDR_W-1 -: 3];
      steps  = sbcc_pkg::BLK_STEPS[blk];
      len    = sbcc_pkg::CNT_W'(int'(steps) * sbcc_pkg::CYC_PER_STEP);
      in_cyc = 1'b0;
      state_next = state_reg;

      // peripheral enable clock as a one-cycle pulse
      state_next.e_en = 1'b0;
      if (state_reg.e_cnt == '0) begin
         state_next.e_cnt = sbcc_pkg::CNT_W'(sbcc_pkg::E_DIV - 1);
         state_next.e_en  = 1'b1;
      end else begin
         state_next.e_cnt = state_reg.e_cnt - 1'b1;
      end

      case (state_reg.own)
         sbcc_pkg::OWN_PROC: begin
            if (!bus.bus_req_n && !bus.grant_out_n) begin
               state_next.own = sbcc_pkg::OWN_HANDOFF;
            end
         end
         sbcc_pkg::OWN_HANDOFF: begin
            if (bus.bus_req_n) begin
               state_next.own = sbcc_pkg::OWN_PROC;
            end else if (bus.addr_strobe_buf_n && bus.data_strobe_n
                         && state_reg.cyc == sbcc_pkg::CYC_IDLE) begin
               state_next.own = sbcc_pkg::OWN_DMA;
               state_next.gack_n = 1'b0;
            end
         end
         sbcc_pkg::OWN_DMA: begin
            if (bus.bus_req_n && bus.addr_strobe_buf_n) begin
               state_next.own    = sbcc_pkg::OWN_PROC;
               state_next.gack_n = 1'b1;
            end
         end
         default: begin
            state_next.own    = sbcc_pkg::OWN_PROC;
            state_next.gack_n = 1'b1;
         end
      endcase
      state_next.dma_owns = (state_next.own == sbcc_pkg::OWN_DMA);

      // bus cycle; a released address strobe always ends it
      if (state_reg.cyc != sbcc_pkg::CYC_IDLE && bus.addr_strobe_buf_n) begin
         state_next.cyc     = sbcc_pkg::CYC_IDLE;
         state_next.dtack_n = 1'b1;
         state_next.vma_n   = 1'b1;
         state_next.gen_n   = 4'hf;
         state_next.bs3_n   = 1'b1;
         state_next.mrd_n   = 1'b1;
      end else begin
         case (state_reg.cyc)
            sbcc_pkg::CYC_IDLE: begin
               if (!bus.addr_strobe_buf_n) begin
                  state_next.gen_n = gen_line_n(steps);
                  state_next.cnt   = len - 1'b1;
                  state_next.bs3_n = ~sbcc_pkg::BLK_IO_MASK[blk];
                  state_next.mrd_n = ~(sbcc_pkg::BLK_MEAS_MASK[blk] & bus.rw_n);
                  state_next.cyc   = sbcc_pkg::CYC_COUNT;
               end
            end
            sbcc_pkg::CYC_COUNT: begin
               in_cyc = 1'b1;
               if (!bus.valid_periph_addr_n) begin
                  state_next.gen_n = 4'hf;
                  state_next.cyc   = sbcc_pkg::CYC_VMA_WAIT;
               end else if (state_reg.cnt == '0) begin
                  state_next.dtack_n = 1'b0;
                  state_next.cyc     = sbcc_pkg::CYC_ACK;
               end else begin
                  state_next.cnt = state_reg.cnt - 1'b1;
               end
            end
            sbcc_pkg::CYC_VMA_WAIT: begin
               in_cyc = 1'b1;
               if (state_reg.e_en) begin
                  state_next.vma_n = 1'b0;
                  state_next.cyc   = sbcc_pkg::CYC_ACK;
               end
            end
            sbcc_pkg::CYC_ACK: begin
               in_cyc = 1'b0;
            end
            default: begin
               state_next.cyc = sbcc_pkg::CYC_IDLE;
            end
         endcase
      end

      // data strobe drives it, ack lifts it
      state_next.grw_n    = ~(in_cyc & ~bus.rw_n & ~bus.data_strobe_n);
      // dma drives its own level, so step off the line then
      state_next.grw_oe_n = (state_next.own == sbcc_pkg::OWN_DMA);
      state_next.cnt_hw_write_ctl_n_n = bus.gated_rd_wr_n;
      state_next.cnt_hw_read_ctl_n_n = bus.meas_read_n;
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         state_reg          <= '0;
         state_reg.own      <= sbcc_pkg::OWN_PROC;
         state_reg.cyc      <= sbcc_pkg::CYC_IDLE;
         state_reg.gack_n   <= sbcc_pkg::STROBE_RST;
         state_reg.dtack_n  <= sbcc_pkg::STROBE_RST;
         state_reg.vma_n    <= sbcc_pkg::STROBE_RST;
         state_reg.gen_n    <= 4'hf;
         state_reg.bs3_n    <= sbcc_pkg::STROBE_RST;
         state_reg.mrd_n    <= sbcc_pkg::STROBE_RST;
         state_reg.grw_n    <= sbcc_pkg::STROBE_RST;
         state_reg.cnt_hw_write_ctl_n_n   <= sbcc_pkg::STROBE_RST;
         state_reg.cnt_hw_read_ctl_n_n   <= sbcc_pkg::STROBE_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   assign bus.grant_ack_n      = state_reg.gack_n;
   assign bus.dtack_n          = state_reg.dtack_n;
   assign bus.valid_mem_addr_n = state_reg.vma_n;
   assign bus.dev_grw_o        = state_reg.grw_n;
   assign bus.dev_grw_oe_n     = state_reg.grw_oe_n;
   assign bus.meas_read_o      = state_reg.mrd_n;
   assign bus.meas_read_oe_n   = 1'b0;

   assign GEN_ACK_1STEP_N    = state_reg.gen_n[0];
   assign GEN_ACK_2STEP_N    = state_reg.gen_n[1];
   assign GEN_ACK_3STEP_N    = state_reg.gen_n[2];
   assign GEN_ACK_5STEP_N    = state_reg.gen_n[3];
   assign BOARD_SEL0_N       = state_reg.gack_n | 1'b1;
   assign BOARD_SEL1_N       = state_reg.gack_n | 1'b1;
   assign BOARD_SEL2_N       = state_reg.gack_n | 1'b1;
   assign BOARD_SEL3_N       = state_reg.bs3_n;
   assign CNT_HW_WRITE_CTL_N = state_reg.cnt_hw_write_ctl_n_n;
   assign CNT_HW_READ_CTL_N  = state_reg.cnt_hw_read_ctl_n_n;
   assign DMA_OWNS           = state_reg.dma_owns;
endmodule
`default_nettype wire

/* sbcc_master.sv */
// bus master end: processor and dma controller sharing one request port
// assumes one request at a time; next request only while REQ_READY is high
`timescale 1ns/100ps
`default_nettype none
module sbcc_master (
   input  wire logic                        REF_CLK,
   input  wire logic                        RST,
   sbcc_if.master                           bus,
   input  wire logic                        REQ_VALID,
   input  wire logic                        REQ_DMA,
   input  wire logic                        REQ_WR,
   input  wire logic [sbcc_pkg::ADDR_W-1:0] REQ_ADDR,
   input  wire logic [1:0]                  REQ_BYTES,
   output logic                             REQ_READY,
   output logic                             DONE,
   output logic                             DONE_PERIPH
);
   typedef struct packed {
      sbcc_pkg::sbcc_mst_e         st;
      logic                        dma;
      logic                        wr;
      logic [sbcc_pkg::ADDR_W-1:0] addr;
      logic [1:0]                  bytes;
      logic                        req_n;
      logic                        bg_n;
      logic                        as_n;
      logic                        ds_n;
      logic                        drive;
      logic                        ready;
      logic                        done;
      logic                        done_p;
   } sbcc_mst_s;

   sbcc_mst_s state_reg;
   sbcc_mst_s state_next;

   always_comb begin
      state_next        = state_reg;
      state_next.done   = 1'b0;
      state_next.done_p = 1'b0;
      // processor lets go between its cycles
      state_next.bg_n = ~(~state_reg.req_n & state_reg.as_n);
      case (state_reg.st)
         sbcc_pkg::M_IDLE: begin
            if (REQ_VALID) begin
               state_next.dma   = REQ_DMA;
               state_next.wr    = REQ_WR;
               state_next.addr  = REQ_ADDR;
               state_next.bytes = REQ_BYTES;
               state_next.ready = 1'b0;
               state_next.req_n = ~REQ_DMA;
               state_next.st    = REQ_DMA ? sbcc_pkg::M_REQ : sbcc_pkg::M_AS;
            end
         end
         sbcc_pkg::M_REQ: begin
            if (!bus.grant_ack_n) begin
               state_next.st = sbcc_pkg::M_AS;
            end
         end
         sbcc_pkg::M_AS: begin
            state_next.drive = 1'b1;
            state_next.as_n  = 1'b0;
            state_next.st    = sbcc_pkg::M_DS;
         end
         sbcc_pkg::M_DS: begin
            state_next.ds_n = 1'b0;
            state_next.st   = sbcc_pkg::M_WAIT;
         end
         sbcc_pkg::M_WAIT: begin
            if (!bus.dtack_n || !bus.valid_mem_addr_n) begin
               state_next.as_n   = 1'b1;
               state_next.ds_n   = 1'b1;
               state_next.drive  = 1'b0;
               state_next.done   = 1'b1;
               state_next.done_p = bus.dtack_n;
               state_next.req_n  = 1'b1;
               state_next.st     = state_reg.dma ? sbcc_pkg::M_REL : sbcc_pkg::M_IDLE;
               state_next.ready  = ~state_reg.dma;
            end
         end
         sbcc_pkg::M_REL: begin
            if (bus.grant_ack_n) begin
               state_next.ready = 1'b1;
               state_next.st    = sbcc_pkg::M_IDLE;
            end
         end
         default: begin
            state_next.st = sbcc_pkg::M_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         state_reg       <= '0;
         state_reg.st    <= sbcc_pkg::M_IDLE;
         state_reg.req_n <= 1'b1;
         state_reg.bg_n  <= 1'b1;
         state_reg.as_n  <= sbcc_pkg::STROBE_RST;
         state_reg.ds_n  <= sbcc_pkg::STROBE_RST;
         state_reg.ready <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign bus.bus_req_n         = state_reg.req_n;
   assign bus.grant_out_n       = state_reg.bg_n;
   assign bus.addr_strobe_buf_n = state_reg.as_n;
   assign bus.data_strobe_n     = state_reg.ds_n;
   assign bus.addr              = state_reg.addr;
   assign bus.rw_o              = ~state_reg.wr;
   assign bus.rw_oe_n           = ~state_reg.drive;
   assign bus.low_byte_o        = ~(state_reg.bytes[0] & ~state_reg.ds_n);
   assign bus.low_byte_oe_n     = ~state_reg.drive;
   assign bus.high_byte_o       = ~(state_reg.bytes[1] & ~state_reg.ds_n);
   assign bus.high_byte_oe_n    = ~state_reg.drive;
   assign bus.mst_grw_o         = 1'b1;
   assign bus.mst_grw_oe_n      = ~(state_reg.dma & state_reg.drive);
   assign REQ_READY             = state_reg.ready;
   assign DONE                  = state_reg.done;
   assign DONE_PERIPH           = state_reg.done_p;
endmodule
`default_nettype wire

/* sbcc_checker.sv */
// assertions on the link between the bus cycle controller and the master end
// assumes one 100 MHz clock and an asynchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module sbcc_checker (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic bus_req_n,
   input wire logic grant_out_n,
   input wire logic grant_ack_n,
   input wire logic addr_strobe_buf_n,
   input wire logic data_strobe_n,
   input wire logic dtack_n,
   input wire logic valid_periph_addr_n,
   input wire logic valid_mem_addr_n,
   input wire logic rw_n,
   input wire logic gated_rd_wr_n,
   input wire logic meas_read_n
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   property p_ack_cause;
      $fell(grant_ack_n) |-> !$past(bus_req_n) && !$past(grant_out_n);
   endproperty
   a_ack_cause: assert property (p_ack_cause)
      else $error("grant ack without request and grant");
   property p_ack_idle;
      $fell(grant_ack_n) |-> $past(addr_strobe_buf_n) && $past(data_strobe_n);
   endproperty
   a_ack_idle: assert property (p_ack_idle)
      else $error("grant ack while processor cycle runs");
   property p_ack_release;
      (!grant_ack_n && bus_req_n && addr_strobe_buf_n) |=> grant_ack_n;
   endproperty
   a_ack_release: assert property (p_ack_release)
      else $error("grant ack held after release");
   property p_no_early_ack;
      $fell(addr_strobe_buf_n) |-> dtack_n [*8];
   endproperty
   a_no_early_ack: assert property (p_no_early_ack)
      else $error("transfer ack before one step");
   // covers the longest step count
   property p_ack_bound;
      $fell(addr_strobe_buf_n) && valid_periph_addr_n |-> ##[10:60] !dtack_n;
   endproperty
   a_ack_bound: assert property (p_ack_bound)
      else $error("cycle never acknowledged");
   // enable pulse phase is free, so the answer lands anywhere in one period
   property p_vma_bound;
      $fell(addr_strobe_buf_n) && !valid_periph_addr_n |-> ##[3:12] !valid_mem_addr_n;
   endproperty
   a_vma_bound: assert property (p_vma_bound)
      else $error("peripheral cycle not answered in time");
   property p_dma_grw;
      (!grant_ack_n && !data_strobe_n) |-> gated_rd_wr_n;
   endproperty
   a_dma_grw: assert property (p_dma_grw)
      else $error("gated line low while dma owns bus");
   property p_grw_read;
      (!data_strobe_n && rw_n) |-> gated_rd_wr_n;
   endproperty
   a_grw_read: assert property (p_grw_read)
      else $error("gated line low on read");
   property p_grw_write;
      (!data_strobe_n && !rw_n && dtack_n && grant_ack_n && valid_periph_addr_n) [*3]
         |-> !gated_rd_wr_n;
   endproperty
   a_grw_write: assert property (p_grw_write)
      else $error("gated line high on write");
   property p_grw_after;
      $fell(dtack_n) |=> ##[0:1] gated_rd_wr_n;
   endproperty
   a_grw_after: assert property (p_grw_after)
      else $error("gated line not released after ack");
   property p_mread_hold;
      (!meas_read_n && !addr_strobe_buf_n) |=> !meas_read_n;
   endproperty
   a_mread_hold: assert property (p_mread_hold)
      else $error("read strobe dropped inside cycle");
   property p_vma_cause;
      $fell(valid_mem_addr_n) |-> !valid_periph_addr_n && !addr_strobe_buf_n;
   endproperty
   a_vma_cause: assert property (p_vma_cause)
      else $error("valid address without peripheral");
endmodule
`default_nettype wire

/* system_bus_cycle_control_bench.sv */
// self-checking bench: controller and master end joined by the link interface
// assumes the package step table and a 100 MHz clock
`timescale 1ns/100ps
`default_nettype none
module system_bus_cycle_control_bench;
   typedef struct packed {
      logic [7:0] len;
      logic [3:0] gen;
      logic       bs3;
      logic       per;
      logic       dma;
      logic [1:0] by;
      logic       grw;
      logic       mrd;
      logic       bad;
   } sbcc_note_s;
   logic        ref_clk;
   logic        rst;
   logic        gen1, gen2, gen3, gen5, bs0, bs1, bs2, bs3, cwr, crd, dma_owns;
   logic        req_valid, req_dma, req_wr, req_ready, done, done_periph;
   logic [17:0] req_addr;
   logic [1:0]  req_bytes;
   int          error_cnt = 0;
   int          n_checks = 0;
   int          run;
   logic        prev_grw, prev_mrd;
   sbcc_note_s  notes[$];
   sbcc_note_s  got, e;

   sbcc_if bus_if ();
   sbcc_ctrl sbcc_ctrl_inst (.REF_CLK(ref_clk), .RST(rst), .bus(bus_if),
      .GEN_ACK_1STEP_N(gen1), .GEN_ACK_2STEP_N(gen2), .GEN_ACK_3STEP_N(gen3),
      .GEN_ACK_5STEP_N(gen5), .BOARD_SEL0_N(bs0), .BOARD_SEL1_N(bs1),
      .BOARD_SEL2_N(bs2), .BOARD_SEL3_N(bs3), .CNT_HW_WRITE_CTL_N(cwr),
      .CNT_HW_READ_CTL_N(crd), .DMA_OWNS(dma_owns));
   sbcc_master sbcc_master_inst (.REF_CLK(ref_clk), .RST(rst), .bus(bus_if),
      .REQ_VALID(req_valid), .REQ_DMA(req_dma), .REQ_WR(req_wr), .REQ_ADDR(req_addr),
      .REQ_BYTES(req_bytes), .REQ_READY(req_ready), .DONE(done),
      .DONE_PERIPH(done_periph));
   sbcc_checker sbcc_checker_inst (.REF_CLK(ref_clk), .RST(rst),
      .bus_req_n(bus_if.bus_req_n), .grant_out_n(bus_if.grant_out_n),
      .grant_ack_n(bus_if.grant_ack_n), .addr_strobe_buf_n(bus_if.addr_strobe_buf_n),
      .data_strobe_n(bus_if.data_strobe_n), .dtack_n(bus_if.dtack_n),
      .valid_periph_addr_n(bus_if.valid_periph_addr_n),
      .valid_mem_addr_n(bus_if.valid_mem_addr_n), .rw_n(bus_if.rw_n),
      .gated_rd_wr_n(bus_if.gated_rd_wr_n), .meas_read_n(bus_if.meas_read_n));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic cmp(input string nm, input logic [7:0] ex, input logic [7:0] g);
      n_checks++;
      if (g !== ex) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, g);
      end
   endtask

   function automatic logic [3:0] gen_of(input logic [2:0] s);
      case (s)
         3'h1: gen_of = 4'h1;
         3'h2: gen_of = 4'h2;
         3'h3: gen_of = 4'h4;
         default: gen_of = 4'h8;
      endcase
   endfunction

   task automatic wait_ready();
      int k;
      for (k = 0; k < 400 && req_ready !== 1'b1; k++) begin
         @(posedge ref_clk);
         #1;
      end
      if (req_ready !== 1'b1) begin
         error_cnt++;
         $display("MISMATCH ready expected 1 seen %b", req_ready);
         give_verdict();
      end
   endtask

   // linger keeps the request up while busy; it must be ignored
   task automatic issue(input logic dma, input logic wr, input logic [2:0] blk,
                        input logic [1:0] by, input logic per, input int linger);
      sbcc_note_s  n;
      logic [17:0] a;
      a = {blk, 15'($urandom)};
      n.len = 8'(sbcc_pkg::BLK_STEPS[blk] * sbcc_pkg::CYC_PER_STEP + 1);
      n.gen = gen_of(sbcc_pkg::BLK_STEPS[blk]);
      n.bs3 = sbcc_pkg::BLK_IO_MASK[blk];
      n.per = per;
      n.dma = dma;
      n.by = by;
      n.grw = wr && !dma;
      n.mrd = sbcc_pkg::BLK_MEAS_MASK[blk] && !wr;
      n.bad = 1'b0;
      notes.push_back(n);
      bus_if.valid_periph_addr_n = !per;
      req_dma = dma;
      req_wr = wr;
      req_addr = a;
      req_bytes = by;
      req_valid = 1'b1;
      wait_ready();
      @(posedge ref_clk);
      #1;
      repeat (linger) begin
         req_addr = ~a;
         @(posedge ref_clk);
         #1;
      end
      req_valid = 1'b0;
      wait_ready();
      bus_if.valid_periph_addr_n = 1'b1;
   endtask

   // monitor gathers what one cycle showed and checks it at its end
   always @(posedge ref_clk) begin
      if (rst) begin
         run = 0;
         got = '0;
         prev_grw = bus_if.gated_rd_wr_n;
         prev_mrd = bus_if.meas_read_n;
      end else begin
         if (!bus_if.addr_strobe_buf_n && bus_if.dtack_n) run++;
         got.gen |= ~{gen5, gen3, gen2, gen1};
         got.bs3 |= !bs3;
         got.dma |= dma_owns;
         if (!bus_if.data_strobe_n) begin
            got.by |= ~{bus_if.high_byte_strobe_n, bus_if.low_byte_strobe_n};
            got.grw |= !bus_if.gated_rd_wr_n;
         end
         got.mrd |= !bus_if.meas_read_n;
         got.bad |= (cwr !== prev_grw) || (crd !== prev_mrd) || !(bs0 && bs1 && bs2);
         prev_grw = bus_if.gated_rd_wr_n;
         prev_mrd = bus_if.meas_read_n;
         if (done === 1'b1) begin
            got.per = done_periph;
            got.len = 8'(run);
            if (notes.size() == 0) begin
               cmp("extra_done", 8'h0, 8'h1);
            end else begin
               e = notes.pop_front();
               if (!e.per) cmp("length", e.len, got.len);
               if (!e.per) cmp("gen_line", 8'(e.gen), 8'(got.gen));
               cmp("board_sel3", 8'(e.bs3), 8'(got.bs3));
               cmp("periph_end", 8'(e.per), 8'(got.per));
               cmp("dma_owns", 8'(e.dma), 8'(got.dma));
               cmp("byte_strobes", 8'(e.by), 8'(got.by));
               cmp("gated_low", 8'(e.grw), 8'(got.grw));
               cmp("meas_read", 8'(e.mrd), 8'(got.mrd));
               cmp("copies_unused", 8'(e.bad), 8'(got.bad));
            end
            run = 0;
            got = '0;
         end
      end
   end

   initial begin
      #300000;
      error_cnt++;
      $display("MISMATCH watchdog expected done seen hang");
      give_verdict();
   end

   initial begin
      rst = 1'b1;
      req_valid = 1'b0;
      req_dma = 1'b0;
      req_wr = 1'b0;
      req_addr = 18'h0;
      req_bytes = 2'h0;
      bus_if.valid_periph_addr_n = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      void'($urandom(32'h2e48));
      for (int b = 0; b < 8; b++) begin
         for (int w = 0; w < 2; w++) begin
            issue(1'b0, w[0], b[2:0], 2'h3, 1'b0, 0);
         end
      end
      issue(1'b1, 1'b0, 3'h3, 2'h2, 1'b0, 0);
      for (int i = 0; i < 12; i++) begin
         issue(1'($urandom), 1'($urandom), 3'($urandom), 2'($urandom_range(1, 3)),
               1'b0, i % 3);
      end
      issue(1'b0, 1'b0, 3'h7, 2'h1, 1'b1, 0);
      issue(1'b0, 1'b0, 3'h5, 2'h2, 1'b1, 1);
      // let the monitor take the last done pulse before reset clears it
      repeat (2) @(posedge ref_clk);
      #1;
      rst = 1'b1;
      @(posedge ref_clk);
      #1;
      rst = 1'b0;
      issue(1'b1, 1'b1, 3'h4, 2'h1, 1'b0, 2);
      repeat (4) @(posedge ref_clk);
      cmp("notes_left", 8'h0, 8'(notes.size()));
      give_verdict();
   end
endmodule
`default_nettype wire
